// *** bench/arc_conditioning_tb.sv ***
// Self-checking testbench of the result conditioning top.
`timescale 1ns/1ps
module arc_conditioning_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic sampleValid = 1'b0;
	logic coreOver = 1'b0;
	logic signed [13:0] coreCode = 14'sh0000;
	logic csN, weN, oeN, dataOeN, externalRefSelect, testInputActive;
	logic powerDown, out_of_range_flag, resultValid;
	logic [1:0] regSelect;
	logic [13:0] dataIn, dataOut, rdv;
	logic [2:0] inputGainSetting, test_input_select;
	int mismatches = 0;
	int compares = 0;
	always #5 core_clk = ~core_clk;
	arc_conditioning i_arc_conditioning (.core_clk(core_clk),
		.arst_n(arst_n), .csN(csN), .weN(weN), .oeN(oeN),
		.regSelect(regSelect), .dataIn(dataIn), .dataOut(dataOut),
		.dataOeN(dataOeN), .sampleValid(sampleValid), .coreCode(coreCode),
		.coreOver(coreOver), .externalRefSelect(externalRefSelect),
		.inputGainSetting(inputGainSetting),
		.test_input_select(test_input_select),
		.testInputActive(testInputActive), .powerDown(powerDown),
		.out_of_range_flag(out_of_range_flag), .resultValid(resultValid));
	arc_host_model i_arc_host_model (.core_clk(core_clk),
		.dataOut(dataOut), .dataOeN(dataOeN), .csN(csN), .weN(weN),
		.oeN(oeN), .regSelect(regSelect), .dataIn(dataIn));
	// ==========================================================
	// Checking and sample tasks
	task chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		compares++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task smp(input logic [13:0] c, input logic ov, input logic [13:0] exp);
		int n;
		@(negedge core_clk);
		coreCode = c;
		coreOver = ov;
		sampleValid = 1'b1;
		@(negedge core_clk);
		sampleValid = 1'b0;
		coreCode = ~c;
		for (n = 0; n < 8 && resultValid !== 1'b1; n++) @(negedge core_clk);
		if (n == 8)
		begin
			mismatches++;
			final_report();
		end
		chk("range flag", 14'(out_of_range_flag), 14'(ov));
		i_arc_host_model.rd(2'h0, rdv);
		chk("result", rdv, exp);
	endtask : smp
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (12) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int a = 1; a < 4; a++)
		begin
			i_arc_host_model.rd(2'(a), rdv);
			chk("reset value", rdv, 14'h0000);
		end
		$display("reset test done");
		i_arc_host_model.wr(2'h1, 14'h3fff);
		i_arc_host_model.rd(2'h1, rdv);
		chk("gain reg", rdv, 14'h0007);
		chk("gain pins", 14'(inputGainSetting), 14'h0007);
		i_arc_host_model.wr(2'h3, 14'h3000);
		chk("ext ref", 14'(externalRefSelect), 14'h0001);
		chk("power down", 14'(powerDown), 14'h0001);
		for (int t = 0; t < 8; t++)
		begin
			i_arc_host_model.wr(2'h3, 14'(t << 8));
			chk("test sel", 14'(test_input_select), 14'(t));
			chk("test act", 14'(testInputActive), 14'(t % 4 != 0));
		end
		chk("ext ref off", 14'(externalRefSelect), 14'h0000);
		$display("control test done");
		i_arc_host_model.wr(2'h3, 14'h0000);
		smp(14'h1fff, 1'b1, 14'h3fff);
		smp(14'h2000, 1'b1, 14'h0000);
		smp(14'h0000, 1'b0, 14'h2000);
		$display("format test done");
		i_arc_host_model.wr(2'h3, 14'h0800);
		smp(14'h0005, 1'b0, 14'h0005);
		i_arc_host_model.wr(2'h3, 14'h0880);
		smp(14'h0005, 1'b0, 14'h0005);
		i_arc_host_model.calibrate();
		i_arc_host_model.rd(2'h2, rdv);
		chk("offset reg", rdv, 14'h0005);
		smp(14'h0005, 1'b0, 14'h0005);
		i_arc_host_model.wr(2'h3, 14'h0800);
		smp(14'h0005, 1'b0, 14'h0000);
		smp(14'h2000, 1'b1, 14'h2000);
		$display("offset test done");
		final_report();
	end
endmodule : arc_conditioning_tb

// *** bench/arc_host_model.sv ***
// Host processor model driving the parallel register bus of the block.
`timescale 1ns/1ps
module arc_host_model (
	input wire logic core_clk,
	input wire logic [13:0] dataOut,
	input wire logic dataOeN,
	output logic csN,
	output logic weN,
	output logic oeN,
	output logic [1:0] regSelect,
	output logic [13:0] dataIn
);
	// The pins float unless the block enables its drivers.
	wire [13:0] busLevel = dataOeN ? 14'hzzzz : dataOut;
	initial
	begin
		csN = 1'b1;
		weN = 1'b1;
		oeN = 1'b1;
		regSelect = 2'h0;
		dataIn = 14'h0000;
	end
	task wait_oe(input logic lvl);
		int n;
		for (n = 0; n < 20 && dataOeN !== lvl; n++) @(negedge core_clk);
		if (n == 20)
		begin
			arc_conditioning_tb.mismatches++;
			arc_conditioning_tb.final_report();
		end
	endtask : wait_oe
	// Held four cycles each way: the block samples three cycles late.
	task wr(input logic [1:0] a, input logic [13:0] d);
		@(negedge core_clk);
		regSelect = a;
		dataIn = d;
		csN = 1'b0;
		weN = 1'b0;
		repeat (4) @(negedge core_clk);
		weN = 1'b1;
		repeat (4) @(negedge core_clk);
		csN = 1'b1;
		regSelect = ~a;
		dataIn = ~d;
	endtask : wr
	task rd(input logic [1:0] a, output logic [13:0] d);
		@(negedge core_clk);
		regSelect = a;
		csN = 1'b0;
		oeN = 1'b0;
		wait_oe(1'b0);
		repeat (2) @(negedge core_clk);
		d = busLevel;
		csN = 1'b1;
		oeN = 1'b1;
		wait_oe(1'b1);
		regSelect = ~a;
	endtask : rd
	// Zero-input result read back and stored as the offset.
	task calibrate();
		logic [13:0] z;
		rd(2'h0, z);
		wr(2'h2, z);
	endtask : calibrate
endmodule : arc_host_model

// *** core/arc_cfg_if.sv ***
// Interface carrying register settings into the conversion pipeline.
`timescale 1ns/1ps
interface arc_cfg_if;
	logic offsetEnable;
	logic twosComp;
	logic signed [7:0] offsetValue;
	modport regs (output offsetEnable, output twosComp, output offsetValue);
	modport pipe (input offsetEnable, input twosComp, input offsetValue);
endinterface : arc_cfg_if

// *** core/arc_conditioning.sv ***
// Top: register file, test input selection and three-state data port.
`timescale 1ns/1ps
module arc_conditioning (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic csN,
	input wire logic weN,
	input wire logic oeN,
	input wire logic [1:0] regSelect,
	input wire logic [13:0] dataIn,
	output logic [13:0] dataOut,
	output logic dataOeN,
	input wire logic sampleValid,
	input wire logic signed [13:0] coreCode,
	input wire logic coreOver,
	output logic externalRefSelect,
	output logic [2:0] inputGainSetting,
	output logic [2:0] test_input_select,
	output logic testInputActive,
	output logic powerDown,
	output logic out_of_range_flag,
	output logic resultValid
);
	logic [2:0] csS_r, weS_r, oeS_r;
	logic [13:0] gain_r, offset_r, control_r;
	logic [13:0] readMux, resultCode, rd_r;
	logic writeStrobe, readActive, wroteGain, wroteOffset, wroteControl;
	logic [2:0] tm;
	logic weLevel_r;
	arc_cfg_if cfg ();

	// Strobes csN, weN, oeN from the host are async: three stages, act when last two agree.
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			csS_r <= 3'h7;
			weS_r <= 3'h7;
			oeS_r <= 3'h7;
			weLevel_r <= 1'b1;
		end
		else
		begin
			csS_r <= {csS_r[1:0], csN};
			weS_r <= {weS_r[1:0], weN};
			oeS_r <= {oeS_r[1:0], oeN};
			if (weS_r[2] == weS_r[1])
				weLevel_r <= weS_r[2];
		end
	end

	// Write taken when the strobe settles high after a settled low, so a
	// single metastable sample on the pin cannot start a second write.
	assign writeStrobe = (weS_r[2:1] == 2'b11) && !weLevel_r &&
		(csS_r[2:1] == 2'b00);
	assign readActive = (oeS_r[2:1] == 2'b00) && (csS_r[2:1] == 2'b00);
	assign wroteGain = writeStrobe && (regSelect == arc_pkg::ADDR_GAIN);
	assign wroteOffset = writeStrobe && (regSelect == arc_pkg::ADDR_OFFSET);
	assign wroteControl = writeStrobe && (regSelect == arc_pkg::ADDR_CONTROL);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			gain_r <= arc_pkg::RST_GAIN;
			offset_r <= arc_pkg::RST_OFFSET;
			control_r <= arc_pkg::RST_CONTROL;
		end
		else
		begin
			if (wroteGain)
				gain_r <= {11'h000, dataIn[2:0]};
			if (wroteOffset)
				offset_r <= {6'h00, dataIn[7:0]};
			if (wroteControl)
				control_r <= dataIn;
		end
	end

	assign externalRefSelect = control_r[arc_pkg::CTL_REF];
	assign inputGainSetting = gain_r[2:0];
	assign powerDown = control_r[arc_pkg::CTL_PWD];
	assign tm = control_r[arc_pkg::CTL_TM_LO +: 3];
	assign test_input_select = tm;
	assign testInputActive = (tm != 3'(arc_pkg::TM_NORMAL)) &&
		(tm != 3'(arc_pkg::TM_NORMAL2));
	assign cfg.offsetEnable = !control_r[arc_pkg::CTL_OFF];
	assign cfg.twosComp = control_r[arc_pkg::CTL_FOR];
	assign cfg.offsetValue = offset_r[7:0];

	arc_result_pipe i_arc_result_pipe (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.cfg(cfg),
		.sampleValid(sampleValid),
		.sampleCode(coreCode),
		.sampleOver(coreOver),
		.resultCode(resultCode),
		.resultOver(out_of_range_flag),
		.resultValid(resultValid)
	);

	assign readMux = (regSelect == arc_pkg::ADDR_RESULT) ? resultCode :
		(regSelect == arc_pkg::ADDR_GAIN) ? gain_r :
		(regSelect == arc_pkg::ADDR_OFFSET) ? offset_r : control_r;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			rd_r <= 14'h0000;
		else
			rd_r <= readMux;
	end

	assign dataOut = rd_r;
	// Enable is low while driving; released whenever not read.
	assign dataOeN = !readActive;

	// Pin history is checked, not the synchroniser, so that a broken
	// synchroniser cannot hide behind its own decode.
	chk_oe_release: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		$past(oeN, 2) && $past(oeN, 3) |-> dataOeN)
		else $error("Data port driven with enable high.");
	chk_oe_drive: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(!$past(oeN, 2) && !$past(oeN, 3) && !$past(csN, 2)
		&& !$past(csN, 3)) |-> !dataOeN)
		else $error("Data port not driven during read.");
	chk_ref_select: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		wroteControl |=> externalRefSelect == $past(dataIn[arc_pkg::CTL_REF]))
		else $error("Reference select not taken from write.");
	chk_gain_write: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		wroteGain |=> inputGainSetting == $past(dataIn[2:0]))
		else $error("Gain setting not taken from write.");
	chk_test_normal: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(tm[1:0] == 2'b00) |-> !testInputActive)
		else $error("Normal test code routed a test input.");
	chk_test_apply: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(tm[1:0] != 2'b00) |-> (testInputActive && test_input_select == tm))
		else $error("Test input not applied.");
	chk_offset_zero: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(sampleValid && !control_r[arc_pkg::CTL_OFF] && offset_r == 14'h0000
		&& control_r[arc_pkg::CTL_FOR] && $stable(control_r))
		##2 $stable(control_r)
		|-> resultCode == $past(coreCode, 2))
		else $error("Result changed with zero offset.");
	chk_zero_code: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(sampleValid && coreCode == 14'h0000
		&& (control_r[arc_pkg::CTL_OFF] || offset_r == 14'h0000))
		##2 (!control_r[arc_pkg::CTL_FOR] && $stable(control_r))
		|-> resultCode == arc_pkg::MID_CODE)
		else $error("Zero input not mid code in binary.");
	chk_over_latency: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		sampleValid ##1 !sampleValid ##1 1'b1
		|-> out_of_range_flag == $past(coreOver, 2))
		else $error("Range flag does not follow sample.");

	cov_write_ctl: cover property (@(posedge core_clk) disable iff (!arst_n)
		wroteControl);
	cov_read: cover property (@(posedge core_clk) disable iff (!arst_n)
		!dataOeN);
	cov_over: cover property (@(posedge core_clk) disable iff (!arst_n)
		out_of_range_flag && resultValid);
endmodule : arc_conditioning

// *** core/arc_pkg.sv ***
// Package of register map, field positions and codes for result conditioning.
// Function
// - REF bit one selects external reference
// - Eight gain steps, zero to seven dB
// - Out-of-range when input exceeds reference
// - Range flag shares data pipeline latency
// - Offset enabled subtracts offset from result
// - Test modes replace input with internal voltages
// - Data pins driven only while enable low
// - Full-scale codes at plus/minus reference
// - Two address bits select four registers
// - Offset control bit zero enables compensation
// - Format bit: zero binary, one twos complement
// - Test codes 000 and 100 normal
package arc_pkg;
	localparam int DATA_W = 14;
	localparam logic [1:0] ADDR_RESULT = 2'h0;
	localparam logic [1:0] ADDR_GAIN = 2'h1;
	localparam logic [1:0] ADDR_OFFSET = 2'h2;
	localparam logic [1:0] ADDR_CONTROL = 2'h3;
	localparam int CTL_PWD = 13;
	localparam int CTL_REF = 12;
	localparam int CTL_FOR = 11;
	localparam int CTL_TM_LO = 8;
	localparam int CTL_OFF = 7;
	localparam int GAIN_W = 3;
	localparam int OFS_W = 8;
	localparam logic [13:0] RST_GAIN = 14'h0000;
	localparam logic [13:0] RST_OFFSET = 14'h0000;
	localparam logic [13:0] RST_CONTROL = 14'h0000;
	localparam logic [13:0] MID_CODE = 14'h2000;
	localparam logic [13:0] POS_FULL = 14'h1fff;
	localparam logic [13:0] NEG_FULL = 14'h2000;
	localparam int PIPE_DEPTH = 2;
	typedef enum logic [2:0] {
		TM_NORMAL = 3'h0, TM_BOTH_NEG = 3'h1, TM_HALF_NEG = 3'h2,
		TM_POS_NEG = 3'h3, TM_NORMAL2 = 3'h4, TM_BOTH_POS = 3'h5,
		TM_NEG_HALF = 3'h6, TM_NEG_POS = 3'h7
	} arc_test_type;
endpackage : arc_pkg

// *** core/arc_result_pipe.sv ***
// Result pipeline: offset subtraction, clamping, format and range flag.
`timescale 1ns/1ps
module arc_result_pipe (
	input wire logic core_clk,
	input wire logic arst_n,
	arc_cfg_if.pipe cfg,
	input wire logic sampleValid,
	input wire logic signed [13:0] sampleCode,
	input wire logic sampleOver,
	output logic [13:0] resultCode,
	output logic resultOver,
	output logic resultValid
);
	logic signed [15:0] corrected;
	logic signed [13:0] clamped;
	logic [13:0] formatted;
	logic signed [13:0] stage_r;
	logic over_r;
	logic valid_r;

	// Subtraction is widened so a saturated sample cannot wrap.
	assign corrected = cfg.offsetEnable ?
		(16'(sampleCode) - 16'(cfg.offsetValue)) : 16'(sampleCode);
	assign clamped = (corrected > 16'sh1fff) ? 14'sh1fff :
		(corrected < -16'sh2000) ? -14'sh2000 : corrected[13:0];
	// Straight binary is the signed code with its top bit flipped.
	assign formatted = cfg.twosComp ? stage_r :
		(stage_r ^ arc_pkg::MID_CODE);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage_r <= 14'sh0000;
			over_r <= 1'b0;
			valid_r <= 1'b0;
			resultCode <= 14'h0000;
			resultOver <= 1'b0;
			resultValid <= 1'b0;
		end
		else
		begin
			valid_r <= sampleValid;
			resultValid <= valid_r;
			if (sampleValid)
			begin
				stage_r <= clamped;
				over_r <= sampleOver;
			end
			if (valid_r)
			begin
				resultCode <= formatted;
				resultOver <= over_r;
			end
		end
	end

	chk_flag_follows_data: assert property (@(posedge core_clk)
		disable iff (!arst_n)
		sampleValid |-> ##2 (resultValid && resultOver == $past(sampleOver, 2)))
		else $error("Range flag out of step with data.");
endmodule : arc_result_pipe
